// ==== fifo_params.svh ====
// Constants shared by both ends of the FIFO link
`ifndef FIFO_PARAMS_SVH
`define FIFO_PARAMS_SVH
`define FIFO_DEPTH 512
`define FIFO_DW 18
`define FIFO_AE_OFFSET 32
`define FIFO_AF_OFFSET 32
`define RT_LAT_ASYNC 3'h3
`define RT_LAT_RCLK 3'h4
`define RT_LAT_WCLK 3'h2
`define ADR_CTRL 8'h00
`define ADR_WDATA 8'h04
`define ADR_CMD 8'h08
`define ADR_STATUS 8'h0C
`define ADR_RDATA 8'h10
`define CTRL_W 6
`define CTRL_ENH 0
`define CTRL_RDUP 1
`define CTRL_OE_N 2
`define CTRL_XIN 3
`define CTRL_FL 4
`define CTRL_LD 5
`define CTRL_RESET 6'h24
`define CMD_READ 0
`define CMD_RT 1
`define HOST_FLAG_MASK 3'h4
`endif

// ==== fifo_pkg.sv ====
// Types shared by both ends of the FIFO link
package fifo_pkg;
  typedef enum logic [1:0] {MODE_STANDALONE, MODE_MASTER, MODE_SLAVE} mode_t;
endpackage : fifo_pkg

// ==== fifo_link_if.sv ====
// Pin-level link between the FIFO device and its controlling logic
`timescale 1ns/10ps
interface fifo_link_if #(parameter int DW = 18) ();
  logic [DW-1:0] data_in;
  logic [DW-1:0] data_out;
  logic data_oe;
  logic write_en_n;
  logic read_en_n;
  logic load_select;
  logic output_en_n;
  logic first_load_retransmit;
  logic write_expansion_in;
  logic read_expansion_in;
  logic write_expansion_out;
  logic read_expansion_out;
  logic enhanced_mode_select_n;
  logic full_flag_n;
  logic empty_flag_n;
  logic almost_full_flag_n;
  logic almost_empty_flag_n;
  modport dev (
    input data_in, write_en_n, read_en_n, load_select, output_en_n,
    input first_load_retransmit, write_expansion_in, read_expansion_in,
    input enhanced_mode_select_n,
    output data_out, data_oe, write_expansion_out, read_expansion_out,
    output full_flag_n, empty_flag_n, almost_full_flag_n, almost_empty_flag_n
  );
  modport host (
    output data_in, write_en_n, read_en_n, load_select, output_en_n,
    output first_load_retransmit, write_expansion_in, read_expansion_in,
    output enhanced_mode_select_n,
    input data_out, data_oe, write_expansion_out, read_expansion_out,
    input full_flag_n, empty_flag_n, almost_full_flag_n, almost_empty_flag_n
  );
endinterface : fifo_link_if

// ==== fifo_dev.sv ====
// FIFO device end: storage, flags, retransmit and token-passing cascade
`timescale 1ns/10ps
`include "fifo_params.svh"

// Behaviour
// [R1] Input-synced half-full defers read effects one edge
// [R2] Output-synced half-full defers write effects one edge
// [R3] Half-full set above half, cleared at half
// [R4] Retransmit accepted regardless of read enable
// [R5] Reader: enable low, load high, enhanced extras
// [R6] Retransmit restarts reading at location zero
// [R7] Asynchronous intermediate flags valid three cycles later
// [R8] Read-synced intermediate flags valid four cycles later
// [R9] Write-synced intermediate flags valid two edges later
// [R10] Retransmit before any write is ignored
// [R11] Controller ignores half/almost-full during one-word retransmit
// [R12] Standalone straps latched while reset held
// [R13] Controller raises retransmit pin to request retransmit
// [R14] Expansion outputs held high during reset
// [R15] Ring: standard mode, one first-load device
// [R16] No retransmit in token ring
// [R17] Only token holder writes or drives outputs
// [R18] Cascade: half-full pin becomes write expansion
// [R19] Controller ANDs active-low full/empty flags
// [R20] Controller gates re-enable on slowest flags
// [R21] Cascade read of last location pulses expansion
// [R22] Incoming read token activates reading next edge
// [R23] After passing token, stop reading, float outputs
// [R24] Half-full threshold is half the depth
module fifo_dev #(
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int DW = `FIFO_DW,
  parameter int AE_OFFSET = `FIFO_AE_OFFSET,
  parameter int AF_OFFSET = `FIFO_AF_OFFSET
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Pins
  fifo_link_if.dev link,
  // Configuration bits
  input wire logic hf_sync_rd_i,
  input wire logic flag_sync_i,
  input wire logic flag_sync_rd_i,
  input wire logic oe_gate_i,
  // State
  output fifo_pkg::mode_t mode_o,
  output logic enhanced_o
);
  import fifo_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [CW-1:0] HALF_CNT = CW'(DEPTH / 2);
  localparam logic [CW-1:0] AF_CNT = CW'(DEPTH - AF_OFFSET);
  localparam logic [CW-1:0] AE_CNT = CW'(AE_OFFSET);
  localparam logic [AW-1:0] LAST_LOC = AW'(DEPTH - 1);

  logic [DW-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [CW-1:0] wcount;
  logic [CW-1:0] rcount;
  logic wrapped;
  logic wrote_any;
  logic wr_tok;
  logic rd_tok;
  logic wr_d;
  logic rd_d;
  logic rt_prev;
  logic [2:0] rt_wait;
  logic half_full_flag_n;
  mode_t next_mode;
  logic cascade;
  logic wr_go;
  logic rd_go;
  logic rt_go;
  logic [CW-1:0] hf_view;
  logic [CW-1:0] stored;

  // Straps sampled while reset is held
  always_comb begin
    if (link.first_load_retransmit) begin
      next_mode = MODE_SLAVE;
    end else if (link.write_expansion_in || link.read_expansion_in) begin
      next_mode = MODE_MASTER;
    end else begin
      next_mode = MODE_STANDALONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_o <= next_mode; // [R12]
      enhanced_o <= ~link.enhanced_mode_select_n;
    end
  end

  assign cascade = (mode_o != MODE_STANDALONE);

  // Enhanced mode reuses the expansion-in pins as duplicate enables
  assign wr_go = ce_i && wr_tok && !link.write_en_n && (wcount != FULL_CNT)
      && (!enhanced_o || link.write_expansion_in) && !rt_go; // [R17]
  assign rd_go = ce_i && rd_tok && !link.read_en_n && link.load_select
      && (rcount != '0) && !rt_go
      && (!enhanced_o || (link.read_expansion_in
      && (!oe_gate_i || !link.output_en_n))); // [R5] [R23]
  // Read enable plays no part here
  assign rt_go = ce_i && !cascade && link.first_load_retransmit && !rt_prev
      && wrote_any; // [R4] [R10] [R16]
  assign stored = wrapped ? FULL_CNT : {1'b0, wptr};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rt_prev <= 1'b0;
    end else if (ce_i) begin
      rt_prev <= link.first_load_retransmit;
    end
  end

  // Storage, one flop row per entry
  for (genvar i = 0; i < DEPTH; i++) begin : g_mem
    always_ff @(posedge clk_i) begin
      if (wr_go && wptr == AW'(i)) begin
        mem[i] <= link.data_in;
      end
    end
  end

  // Write pointer and write token
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wptr <= '0;
      wrapped <= 1'b0;
      wrote_any <= 1'b0;
      wr_tok <= (next_mode != MODE_SLAVE);
    end else if (ce_i) begin
      if (wr_go) begin
        wptr <= (wptr == LAST_LOC) ? '0 : wptr + 1'b1;
        wrote_any <= 1'b1;
        if (wptr == LAST_LOC) begin
          wrapped <= 1'b1;
          if (cascade) begin
            wr_tok <= 1'b0; // [R17]
          end
        end
      end else if (cascade && !enhanced_o && !link.write_expansion_in) begin
        wr_tok <= 1'b1;
      end
    end
  end

  // Read pointer and read token
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rptr <= '0;
      rd_tok <= (next_mode != MODE_SLAVE);
    end else if (ce_i) begin
      if (rt_go) begin
        rptr <= '0; // [R6]
      end else if (rd_go) begin
        rptr <= (rptr == LAST_LOC) ? '0 : rptr + 1'b1;
        if (cascade && rptr == LAST_LOC) begin
          rd_tok <= 1'b0; // [R23]
        end
      end else if (cascade && !enhanced_o && !link.read_expansion_in) begin
        rd_tok <= 1'b1; // [R22]
      end
    end
  end

  // Each port sees the other port's event one edge late
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_d <= 1'b0;
      rd_d <= 1'b0;
      wcount <= '0;
      rcount <= '0;
    end else if (ce_i) begin
      wr_d <= wr_go;
      rd_d <= rd_go;
      if (rt_go) begin
        wcount <= stored;
        rcount <= stored;
      end else begin
        wcount <= wcount + CW'(wr_go) - CW'(rd_d); // [R1]
        rcount <= rcount + CW'(wr_d) - CW'(rd_go); // [R2]
      end
    end
  end

  assign hf_view = hf_sync_rd_i ? rcount : wcount;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      half_full_flag_n <= 1'b1;
      link.full_flag_n <= 1'b1;
      link.empty_flag_n <= 1'b0;
    end else if (ce_i) begin
      half_full_flag_n <= !(hf_view > HALF_CNT); // [R3] [R24]
      link.full_flag_n <= (wcount != FULL_CNT);
      link.empty_flag_n <= (rcount != '0);
    end
  end

  // Intermediate flags hold their old state until the settle time ends
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rt_wait <= '0;
      link.almost_full_flag_n <= 1'b1;
      link.almost_empty_flag_n <= 1'b0;
    end else if (ce_i) begin
      if (rt_go) begin
        rt_wait <= !flag_sync_i ? `RT_LAT_ASYNC : // [R7]
            (flag_sync_rd_i ? `RT_LAT_RCLK : `RT_LAT_WCLK); // [R8] [R9]
      end else if (rt_wait != '0) begin
        rt_wait <= rt_wait - 1'b1;
      end
      if (!rt_go && rt_wait <= 3'h1) begin
        link.almost_full_flag_n <= (wcount < AF_CNT);
        link.almost_empty_flag_n <= (rcount > AE_CNT);
      end
    end
  end

  // Expansion pins and read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.write_expansion_out <= 1'b1; // [R14]
      link.read_expansion_out <= 1'b1;
      link.data_out <= '0;
      link.data_oe <= 1'b0;
    end else if (ce_i) begin
      link.write_expansion_out <= cascade ?
          !(wr_go && wptr == LAST_LOC) : half_full_flag_n; // [R18]
      link.read_expansion_out <= !(cascade && rd_go && rptr == LAST_LOC); // [R21]
      if (rd_go) begin
        link.data_out <= mem[rptr];
      end
      link.data_oe <= !link.output_en_n && rd_tok
          && !(cascade && rd_go && rptr == LAST_LOC); // [R17] [R23]
    end
  end
endmodule : fifo_dev

// ==== fifo_host.sv ====
// Controller end: Wishbone registers driving the FIFO pins
`timescale 1ns/10ps
`include "fifo_params.svh"

module fifo_host #(
  parameter int DW = `FIFO_DW
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins
  fifo_link_if.host link
);
  import fifo_pkg::*;

  logic [`CTRL_W-1:0] ctrl;
  logic [DW-1:0] rdata;
  logic rd_p1;
  logic rd_p2;
  logic [2:0] mask_cnt;
  logic req;
  logic wr_req;
  logic [31:0] next_dat;
  logic full_all_n;
  logic empty_all_n;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  assign wr_req = req && wb_we_i && wb_sel_i[0];
  // Composite of one device; wider arrays AND further flags in here
  assign full_all_n = link.full_flag_n; // [R19]
  assign empty_all_n = link.empty_flag_n; // [R19]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `CTRL_RESET;
    end else if (wr_req && wb_adr_i == `ADR_CTRL) begin
      ctrl <= wb_dat_i[`CTRL_W-1:0];
    end
  end

  // Straps follow ctrl, so a device-only reset with ctrl set picks the mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.first_load_retransmit <= 1'b0; // [R12]
      link.enhanced_mode_select_n <= 1'b1;
      link.write_expansion_in <= 1'b0;
      link.read_expansion_in <= 1'b0;
      link.output_en_n <= 1'b1;
      link.load_select <= 1'b1;
    end else if (ce_i) begin
      link.enhanced_mode_select_n <= !ctrl[`CTRL_ENH];
      link.write_expansion_in <= ctrl[`CTRL_XIN];
      link.read_expansion_in <= ctrl[`CTRL_ENH] ? ctrl[`CTRL_RDUP] : ctrl[`CTRL_XIN]; // [R5]
      link.output_en_n <= ctrl[`CTRL_OE_N];
      link.load_select <= ctrl[`CTRL_LD]; // [R5]
      link.first_load_retransmit <= ctrl[`CTRL_FL] ||
          (wr_req && wb_adr_i == `ADR_CMD && wb_dat_i[`CMD_RT]); // [R13] [R15]
    end
  end

  // Strobes refused while the flags say the device cannot take them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.write_en_n <= 1'b1;
      link.read_en_n <= 1'b1;
      link.data_in <= '0;
    end else if (ce_i) begin
      link.write_en_n <= !(wr_req && wb_adr_i == `ADR_WDATA && full_all_n); // [R20]
      link.read_en_n <= !(wr_req && wb_adr_i == `ADR_CMD && wb_dat_i[`CMD_READ]
          && empty_all_n); // [R20]
      if (wr_req && wb_adr_i == `ADR_WDATA) begin
        link.data_in <= wb_dat_i[DW-1:0];
      end
    end
  end

  // Data is captured two edges after the device takes the read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_p1 <= 1'b0;
      rd_p2 <= 1'b0;
      rdata <= '0;
    end else if (ce_i) begin
      rd_p1 <= !link.read_en_n;
      rd_p2 <= rd_p1;
      if (rd_p2) begin
        rdata <= link.data_out;
      end
    end
  end

  // Half and almost-full are unreliable right after a retransmit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_cnt <= '0;
    end else if (ce_i) begin
      if (wr_req && wb_adr_i == `ADR_CMD && wb_dat_i[`CMD_RT]) begin
        mask_cnt <= `HOST_FLAG_MASK; // [R11]
      end else if (mask_cnt != '0) begin
        mask_cnt <= mask_cnt - 1'b1;
      end
    end
  end

  always_comb begin
    next_dat = 32'h0000_0000;
    unique case (wb_adr_i)
      `ADR_CTRL: next_dat = {{(32-`CTRL_W){1'b0}}, ctrl};
      `ADR_STATUS: next_dat = {26'h0, link.data_oe, link.read_expansion_out,
          link.write_expansion_out && (mask_cnt == '0), // [R11]
          link.almost_full_flag_n || (mask_cnt != '0),
          link.almost_empty_flag_n, full_all_n};
      `ADR_RDATA: next_dat = {{(32-DW){1'b0}}, rdata};
      default: next_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= next_dat;
      end
    end
  end
endmodule : fifo_host

// ==== fifo_link_properties.sv ====
// Pin-level checks on the link between FIFO controller and device
`timescale 1ns/10ps
module fifo_link_properties #(
  parameter int DEPTH = 512,
  parameter int AE_OFFSET = 32,
  parameter int AF_OFFSET = 32
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link pins
  input wire logic write_en_n,
  input wire logic read_en_n,
  input wire logic load_select,
  input wire logic first_load_retransmit,
  input wire logic write_expansion_out,
  input wire logic read_expansion_out,
  input wire logic full_flag_n,
  input wire logic empty_flag_n,
  input wire logic almost_full_flag_n,
  input wire logic almost_empty_flag_n
);
  logic [10:0] cnt;
  logic [10:0] wr_total;
  logic rt_q;
  logic wr_ok;
  logic rd_ok;
  assign wr_ok = !write_en_n && full_flag_n;
  assign rd_ok = !read_en_n && load_select && empty_flag_n;
  always_ff @(posedge clk_i) begin
    if (rst_i) rt_q <= 1'b0;
    else rt_q <= first_load_retransmit;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) wr_total <= 11'h000;
    else wr_total <= wr_total + 11'(wr_ok);
  end
  // Rewind re-reads from location zero, so occupancy is all words written
  always_ff @(posedge clk_i) begin
    if (rst_i) cnt <= 11'h000;
    else if (first_load_retransmit && !rt_q && wr_total != 11'h000) cnt <= wr_total;
    else cnt <= cnt + 11'(wr_ok) - 11'(rd_ok);
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence rt_loaded;
    $rose(first_load_retransmit) && (wr_total != 11'h000);
  endsequence
  sequence rt_unloaded;
    $rose(first_load_retransmit) && (wr_total == 11'h000);
  endsequence
  a_reset_expand_high : assert property (disable iff (1'b0)
    rst_i |=> write_expansion_out && read_expansion_out)
    else $error("Expansion output low after reset edge");
  a_solo_read_token : assert property (read_expansion_out)
    else $error("Read expansion pulsed in standalone use");
  a_hf_over_half : assert property (
    (cnt > DEPTH / 2) [*4] |-> !write_expansion_out)
    else $error("Half-full missing above half");
  a_hf_at_half : assert property (
    (cnt <= DEPTH / 2) [*4] |-> write_expansion_out)
    else $error("Half-full shown at or below half");
  a_rt_idle_noop : assert property (
    rt_unloaded |=> $stable({full_flag_n, empty_flag_n, almost_full_flag_n,
      almost_empty_flag_n, write_expansion_out}) [*3])
    else $error("Idle rewind changed flags");
  a_rt_async_flags : assert property (rt_loaded |-> ##4
    (almost_empty_flag_n == (cnt > AE_OFFSET)) && (almost_full_flag_n == (cnt < DEPTH - AF_OFFSET)))
    else $error("Almost flags wrong after rewind");
  a_rt_not_empty : assert property (rt_loaded |-> ##[1:4] empty_flag_n)
    else $error("Empty after rewind with data");
  a_write_fills : assert property (
    wr_ok && !empty_flag_n |-> ##[1:3] empty_flag_n)
    else $error("Empty flag stuck after write");
endmodule : fifo_link_properties

// ==== fifo_retransmit_flags_cascade_tb.sv ====
// Self-checking bench joining the FIFO controller and device ends
`timescale 1ns/10ps
`include "fifo_params.svh"
module fifo_retransmit_flags_cascade_tb;
  import fifo_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hf_sync_rd_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  mode_t mode_o;
  logic enhanced_o;
  logic [63:0] notes[$];
  logic [63:0] note;
  logic [17:0] mem[0:299];
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  int seed = 5098;
  logic ce = 1'b1;
  logic rst_dev = 1'b0;
  logic [3:0] sel = 4'hF;
  fifo_link_if #(.DW(18)) link ();
  fifo_host u_fifo_host (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
    .wb_dat_o(rdat), .wb_ack_o(ack), .link(link.host));
  fifo_dev u_fifo_dev (.clk_i(clk_i), .rst_i(rst_i || rst_dev), .ce_i(ce), .link(link.dev),
    .hf_sync_rd_i(hf_sync_rd_i), .flag_sync_i(1'b0), .flag_sync_rd_i(1'b0),
    .oe_gate_i(1'b0), .mode_o(mode_o), .enhanced_o(enhanced_o));
  fifo_link_properties #(.DEPTH(`FIFO_DEPTH), .AE_OFFSET(`FIFO_AE_OFFSET),
    .AF_OFFSET(`FIFO_AF_OFFSET)) u_fifo_link_properties (.clk_i(clk_i),
    .rst_i(rst_i || rst_dev),
    .write_en_n(link.write_en_n), .read_en_n(link.read_en_n), .load_select(link.load_select),
    .first_load_retransmit(link.first_load_retransmit),
    .write_expansion_out(link.write_expansion_out),
    .read_expansion_out(link.read_expansion_out), .full_flag_n(link.full_flag_n),
    .empty_flag_n(link.empty_flag_n), .almost_full_flag_n(link.almost_full_flag_n),
    .almost_empty_flag_n(link.almost_empty_flag_n));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // Expected value and mask travel together to the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back({e & m, m});
    wb(1'b0, a, 32'h0);
  endtask : rd
  task automatic do_reset();
    rst_i <= 1'b1;
    hf_sync_rd_i <= 1'($random(seed));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(32'(mode_o), 32'(MODE_STANDALONE));
    check({31'h0, enhanced_o}, 32'h0);
    rd(`ADR_STATUS, 32'h1D, 32'h3F);
  endtask : do_reset
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && notes.size() > 0) begin
      note = notes.pop_front();
      check(rdat & note[31:0], note[63:32]);
    end
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 12000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    do_reset();
    rd(`ADR_CTRL, 32'h24, 32'h3F);
    rd(8'h20, 32'h0, 32'hFFFFFFFF);
    wb(1'b1, `ADR_CMD, 32'h2);
    // Host hides half-full briefly after a rewind, so let that pass
    repeat (6) @(posedge clk_i);
    rd(`ADR_STATUS, 32'h1D, 32'h3F);
    $display("Test reset and idle rewind done");
    for (int i = 0; i < 300; i++) begin
      mem[i] = 18'($random(seed));
      wb(1'b1, `ADR_WDATA, {14'h0, mem[i]});
      if (i == 255 || i == 256) begin
        repeat (4) @(posedge clk_i);
        rd(`ADR_STATUS, (i == 255) ? 32'h8 : 32'h0, 32'h8);
      end
    end
    $display("Test fill past half done");
    wb(1'b1, `ADR_CTRL, 32'h20);
    rd(`ADR_CTRL, 32'h20, 32'h3F);
    rd(`ADR_STATUS, 32'h20, 32'h20);
    for (int j = 0; j < 280; j++) begin
      wb(1'b1, `ADR_CMD, 32'h1);
      @(posedge clk_i);
      rd(`ADR_RDATA, {14'h0, mem[j]}, 32'h3FFFF);
      if (j == 43) begin
        repeat (4) @(posedge clk_i);
        rd(`ADR_STATUS, 32'h8, 32'h8);
      end
    end
    $display("Test drain to low level done");
    wb(1'b1, `ADR_CMD, 32'h3);
    repeat (6) @(posedge clk_i);
    rd(`ADR_STATUS, 32'h7, 32'hF);
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, `ADR_CMD, 32'h1);
      @(posedge clk_i);
      rd(`ADR_RDATA, {14'h0, mem[k]}, 32'h3FFFF);
    end
    $display("Test rewind with data done");
    // Device-only reset so the straps taken from ctrl pick the ring master role
    wb(1'b1, `ADR_CTRL, 32'h2C);
    rst_dev <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_dev <= 1'b0;
    @(posedge clk_i);
    check(32'(mode_o), 32'(MODE_MASTER));
    sel <= 4'hE;
    wb(1'b1, `ADR_WDATA, 32'h3FFFF);
    sel <= 4'hF;
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, `ADR_WDATA, {14'h0, mem[k + 10]});
    end
    ce <= 1'b0;
    repeat (3) @(posedge clk_i);
    ce <= 1'b1;
    wb(1'b1, `ADR_CMD, 32'h1);
    @(posedge clk_i);
    rd(`ADR_RDATA, {14'h0, mem[10]}, 32'h3FFFF);
    wb(1'b1, `ADR_CMD, 32'h2);
    repeat (6) @(posedge clk_i);
    wb(1'b1, `ADR_CMD, 32'h1);
    @(posedge clk_i);
    rd(`ADR_RDATA, {14'h0, mem[11]}, 32'h3FFFF);
    $display("Test ring master done");
    do_reset();
    $display("Test second reset done");
    report_and_stop();
  end
endmodule : fifo_retransmit_flags_cascade_tb
